// ### core/dstg_pkg.sv
package dstg_pkg;

  // ---------------------------------------------------------------
  // widths and depths
  // ---------------------------------------------------------------
  localparam int CFG_W = 12;
  localparam int PIX_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int FRAME_CNT_W = 16;

  // ---------------------------------------------------------------
  // mode encodings
  // ---------------------------------------------------------------
  localparam logic MODE_TFT = 1'h0;
  localparam logic MODE_PAR = 1'h1;

  // ---------------------------------------------------------------
  // levels and reset values
  // ---------------------------------------------------------------
  localparam logic STROBE_IDLE_N = 1'h1;
  localparam logic STROBE_ACT_N = 1'h0;
  localparam logic POL_RST = 1'h0;

  // ---------------------------------------------------------------
  // parallel interface sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_STROBE = 3'h2,
    ST_GAP = 3'h4
  } dstg_par_t;

endpackage

// ### core/dstg_sync.sv
`timescale 1ns/1ps
module dstg_sync
  import dstg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // level crossing
  input wire logic d_i,
  output logic q_o
);

  typedef struct packed {
    logic meta;
    logic q;
  } dstg_sync_t;

  dstg_sync_t r;
  dstg_sync_t next_r;

  always_comb begin
    next_r.meta = d_i;
    next_r.q = r.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.q;

endmodule

// ### core/dstg_fifo.sv
`timescale 1ns/1ps
module dstg_fifo
  import dstg_pkg::*;
#(
  parameter int W = PIX_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // write side
  input wire logic wclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  // read side
  input wire logic rclk_i,
  output logic [W-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);

  // depth must be a power of two, at least 4
  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // ---------------------------------------------------------------
  // write domain
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wbin;
    logic [AW:0] rg1;
    logic [AW:0] rg2;
    logic [AW:0] wgray;
    logic full_n;
  } dstg_fifo_w_t;

  // ---------------------------------------------------------------
  // read domain
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [AW:0] rbin;
    logic [AW:0] rgray;
    logic [AW:0] wg1;
    logic [AW:0] wg2;
    logic [W-1:0] dout;
    logic dvalid;
  } dstg_fifo_r_t;

  dstg_fifo_w_t rw;
  dstg_fifo_w_t next_rw;
  dstg_fifo_r_t rr;
  dstg_fifo_r_t next_rr;

  always_comb begin
    logic [AW:0] wb;
    wb = '0;
    next_rw = rw;
    // gray pointers cross from flops, never from decode logic that can glitch
    next_rw.rg1 = rr.rgray;
    next_rw.rg2 = rw.rg1;
    if (wr_valid_i && rw.full_n) begin
      next_rw.mem[rw.wbin[AW-1:0]] = wr_data_i;
    end
    wb = AW'(0) + rw.wbin + {{AW{1'h0}}, wr_valid_i && rw.full_n};
    next_rw.wbin = wb;
    next_rw.wgray = bin2gray(wb);
    // full is pessimistic while the read pointer is in flight
    next_rw.full_n = bin2gray(wb) != {~rw.rg2[AW:AW-1], rw.rg2[AW-2:0]};
  end

  always_comb begin
    logic load;
    load = 1'h0;
    next_rr = rr;
    next_rr.wg1 = rw.wgray;
    next_rr.wg2 = rr.wg1;
    load = (!rr.dvalid || rd_ready_i) && (bin2gray(rr.rbin) != rr.wg2);
    if (load) begin
      next_rr.dout = rw.mem[rr.rbin[AW-1:0]];
      next_rr.rbin = (AW+1)'(rr.rbin + 1'h1);
      next_rr.dvalid = 1'h1;
    end else if (rd_ready_i) begin
      next_rr.dvalid = 1'h0;
    end
    next_rr.rgray = bin2gray(next_rr.rbin);
  end

  always_ff @(posedge wclk_i or posedge rst_i) begin
    if (rst_i) begin
      rw <= '0;
      rw.full_n <= 1'h1;
    end else begin
      rw <= next_rw;
    end
  end

  always_ff @(posedge rclk_i or posedge rst_i) begin
    if (rst_i) begin
      rr <= '0;
    end else begin
      rr <= next_rr;
    end
  end

  assign wr_ready_o = rw.full_n;
  assign rd_data_o = rr.dout;
  assign rd_valid_o = rr.dvalid;

endmodule

// ### core/dstg_top.sv
`timescale 1ns/1ps
// Contract
// RULE1: every sync control is timed from the line/frame local start point.
// RULE2: each control has its own offset, up and down values; the vertical active window has only up and down, its offset fixed at 0.
// RULE3: all placement resolves in whole display clock periods only.
// RULE4: pixel data follows a fixed phase to the start point, not programmable.
// RULE5: the display internal clock is the time base of every control.
// RULE6: with positive clock polarity the panel captures on the falling edge.
// RULE7: pixel clock toggles continuously while active, never gated between lines.
// RULE8: line sync pulses once per line to start a new line.
// RULE9: frame sync starts a frame and spans at least one whole line sync.
// RULE10: data valid enable marks shifted pixels; data outside it is invalid.
// RULE11: clock, line sync, frame sync and enable polarities are selectable.
// RULE12: totals, sync widths, porches and active periods are all programmable.
// RULE13: single access mode leaves all strobes inactive one clock after access.
// RULE14: burst access mode strobes the write line for every word.
// RULE15: horizontal counter restarts each line, vertical counter each frame.
module dstg_top
  import dstg_pkg::*;
#(
  parameter int CW = CFG_W,
  parameter int PW = PIX_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int FW = FRAME_CNT_W
) (
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // display internal clock
  input wire logic display_internal_clock_i,
  // pixel stream in
  input wire logic [PW-1:0] pix_data_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  // control, taken while disabled
  input wire logic enable_i,
  input wire logic mode_i,
  input wire logic burst_i,
  input wire logic pol_clk_i,
  input wire logic pol_hs_i,
  input wire logic pol_vs_i,
  input wire logic pol_de_i,
  // horizontal timing, display clocks
  input wire logic [CW-1:0] h_total_i,
  input wire logic [CW-1:0] hs_off_i,
  input wire logic [CW-1:0] hs_up_i,
  input wire logic [CW-1:0] hs_down_i,
  input wire logic [CW-1:0] de_off_i,
  input wire logic [CW-1:0] de_up_i,
  input wire logic [CW-1:0] de_down_i,
  // vertical timing, lines
  input wire logic [CW-1:0] v_total_i,
  input wire logic [CW-1:0] vs_off_i,
  input wire logic [CW-1:0] vs_up_i,
  input wire logic [CW-1:0] vs_down_i,
  input wire logic [CW-1:0] va_up_i,
  input wire logic [CW-1:0] va_down_i,
  // status
  input wire logic underrun_clr_i,
  output logic underrun_o,
  output logic active_o,
  output logic [FW-1:0] frame_count_o,
  // panel side
  output logic pixel_clock_out_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic data_valid_enable_o,
  output logic [PW-1:0] pix_data_o,
  output logic cs_n_o,
  output logic wr_n_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // window test relative to a start point, wraps modulo the counter
  function automatic logic in_win(input logic [CW-1:0] c, input logic [CW-1:0] off,
                                  input logic [CW-1:0] up, input logic [CW-1:0] dn);
    logic [CW-1:0] rel;
    rel = CW'(c - off);
    return (rel >= up) && (rel < dn);
  endfunction

  function automatic logic [CW-1:0] step(input logic [CW-1:0] c, input logic [CW-1:0] total);
    return (c == CW'(total - 1'h1)) ? '0 : CW'(c + 1'h1);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CW-1:0] h_total;
    logic [CW-1:0] hs_off;
    logic [CW-1:0] hs_up;
    logic [CW-1:0] hs_dn;
    logic [CW-1:0] de_off;
    logic [CW-1:0] de_up;
    logic [CW-1:0] de_dn;
    logic [CW-1:0] v_total;
    logic [CW-1:0] vs_off;
    logic [CW-1:0] vs_up;
    logic [CW-1:0] vs_dn;
    logic [CW-1:0] va_up;
    logic [CW-1:0] va_dn;
    logic p_clk;
    logic p_hs;
    logic p_vs;
    logic p_de;
    logic mode;
    logic burst;
    logic [CW-1:0] hcnt;
    logic [CW-1:0] vcnt;
    logic running;
    logic utgl;
    logic ftgl;
    logic pclk;
    logic hs;
    logic vs;
    logic de;
    logic [PW-1:0] data;
    logic cs_n;
    logic wr_n;
    dstg_par_t st;
  } dstg_link_t;

  typedef struct packed {
    logic utgl_d;
    logic ftgl_d;
    logic underrun;
    logic [FW-1:0] frames;
  } dstg_sys_t;

  dstg_link_t rl;
  dstg_link_t next_rl;
  dstg_sys_t rs;
  dstg_sys_t next_rs;

  logic en_s;
  logic run_s;
  logic utgl_s;
  logic ftgl_s;
  logic [PW-1:0] fifo_data;
  logic fifo_valid;
  logic pop;

  // ---------------------------------------------------------------
  // crossings and buffer
  // ---------------------------------------------------------------
  dstg_sync u_en_sync (
    .clk_i(display_internal_clock_i),
    .rst_i(rst_i),
    .d_i(enable_i),
    .q_o(en_s)
  );

  dstg_sync u_run_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(rl.running),
    .q_o(run_s)
  );

  dstg_sync u_under_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(rl.utgl),
    .q_o(utgl_s)
  );

  dstg_sync u_frame_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(rl.ftgl),
    .q_o(ftgl_s)
  );

  dstg_fifo #(
    .W(PW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .wclk_i(clk_i),
    .rst_i(rst_i),
    .wr_data_i(pix_data_i),
    .wr_valid_i(pix_valid_i),
    .wr_ready_o(pix_ready_o),
    .rclk_i(display_internal_clock_i),
    .rd_data_o(fifo_data),
    .rd_valid_o(fifo_valid),
    .rd_ready_i(pop)
  );

  // ---------------------------------------------------------------
  // link domain: timing generator and parallel sequencer
  // ---------------------------------------------------------------
  always_comb begin
    logic de_act;
    logic last_h;
    de_act = 1'h0;
    last_h = 1'h0;
    pop = 1'h0;
    next_rl = rl;
    if (!en_s) begin
      // config words only sampled while stopped; they must be stable then
      next_rl.h_total = h_total_i; // RULE12
      next_rl.hs_off = hs_off_i; // RULE2
      next_rl.hs_up = hs_up_i;
      next_rl.hs_dn = hs_down_i;
      next_rl.de_off = de_off_i;
      next_rl.de_up = de_up_i;
      next_rl.de_dn = de_down_i;
      next_rl.v_total = v_total_i;
      next_rl.vs_off = vs_off_i;
      next_rl.vs_up = vs_up_i;
      // frame sync never shorter than one whole line
      next_rl.vs_dn = (vs_down_i > vs_up_i) ? vs_down_i : CW'(vs_up_i + 1'h1); // RULE9
      next_rl.va_up = va_up_i;
      next_rl.va_dn = va_down_i;
      next_rl.p_clk = pol_clk_i; // RULE11
      next_rl.p_hs = pol_hs_i;
      next_rl.p_vs = pol_vs_i;
      next_rl.p_de = pol_de_i;
      next_rl.mode = mode_i;
      next_rl.burst = burst_i;
      next_rl.hcnt = '0;
      next_rl.vcnt = '0;
      next_rl.running = 1'h0;
      next_rl.pclk = pol_clk_i;
      next_rl.hs = pol_hs_i;
      next_rl.vs = pol_vs_i;
      next_rl.de = pol_de_i;
      next_rl.data = '0;
      next_rl.cs_n = STROBE_IDLE_N;
      next_rl.wr_n = STROBE_IDLE_N;
      next_rl.st = ST_IDLE;
    end else begin
      next_rl.running = 1'h1;
      // one count per display clock, so placement is in whole periods
      last_h = rl.hcnt == CW'(rl.h_total - 1'h1); // RULE3 RULE5
      next_rl.hcnt = step(rl.hcnt, rl.h_total); // RULE15
      if (last_h) begin
        next_rl.vcnt = step(rl.vcnt, rl.v_total); // RULE15
        if (rl.vcnt == CW'(rl.v_total - 1'h1)) begin
          next_rl.ftgl = !rl.ftgl;
        end
      end
      if (rl.mode == MODE_TFT) begin
        // with clock polarity 0, even counts raise the clock with new data and odd counts drop it; polarity 1 inverts both
        next_rl.pclk = !rl.hcnt[0] ^ rl.p_clk; // RULE6 RULE7
        next_rl.hs = in_win(rl.hcnt, rl.hs_off, rl.hs_up, rl.hs_dn) ^ rl.p_hs; // RULE1 RULE8
        next_rl.vs = in_win(rl.vcnt, rl.vs_off, rl.vs_up, rl.vs_dn) ^ rl.p_vs; // RULE1 RULE9
        de_act = in_win(rl.hcnt, rl.de_off, rl.de_up, rl.de_dn)
                 && in_win(rl.vcnt, '0, rl.va_up, rl.va_dn); // RULE1
        if (!rl.hcnt[0]) begin
          // data rides with the enable, no separate phase control
          next_rl.de = de_act ^ rl.p_de; // RULE10
          next_rl.data = '0; // RULE4
          if (de_act) begin
            pop = fifo_valid;
            next_rl.data = fifo_valid ? fifo_data : '0;
            next_rl.utgl = fifo_valid ? rl.utgl : !rl.utgl;
          end
        end
      end else begin
        next_rl.pclk = rl.p_clk;
        next_rl.hs = rl.p_hs;
        next_rl.vs = rl.p_vs;
        next_rl.de = rl.p_de;
        case (rl.st)
          ST_IDLE, ST_GAP: begin
            if (fifo_valid) begin
              pop = 1'h1;
              next_rl.data = fifo_data;
              next_rl.cs_n = STROBE_ACT_N;
              next_rl.wr_n = STROBE_ACT_N;
              next_rl.st = ST_STROBE;
            end else begin
              next_rl.cs_n = STROBE_IDLE_N;
              next_rl.wr_n = STROBE_IDLE_N;
              next_rl.st = ST_IDLE;
            end
          end
          ST_STROBE: begin
            next_rl.wr_n = STROBE_IDLE_N; // RULE14
            // burst keeps select low across words, single drops everything
            next_rl.cs_n = rl.burst ? STROBE_ACT_N : STROBE_IDLE_N; // RULE13
            next_rl.st = ST_GAP;
          end
          default: begin
            next_rl.cs_n = STROBE_IDLE_N;
            next_rl.wr_n = STROBE_IDLE_N;
            next_rl.st = ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge display_internal_clock_i or posedge rst_i) begin
    if (rst_i) begin
      rl <= '0;
      rl.cs_n <= STROBE_IDLE_N;
      rl.wr_n <= STROBE_IDLE_N;
      rl.st <= ST_IDLE;
    end else begin
      rl <= next_rl;
    end
  end

  // ---------------------------------------------------------------
  // system domain: status
  // ---------------------------------------------------------------
  always_comb begin
    next_rs = rs;
    next_rs.utgl_d = utgl_s;
    next_rs.ftgl_d = ftgl_s;
    // a new underrun wins over a clear in the same cycle
    next_rs.underrun = (utgl_s ^ rs.utgl_d) || (rs.underrun && !underrun_clr_i);
    if (ftgl_s ^ rs.ftgl_d) begin
      next_rs.frames = FW'(rs.frames + 1'h1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rs <= '0;
    end else begin
      rs <= next_rs;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign underrun_o = rs.underrun;
  assign active_o = run_s;
  assign frame_count_o = rs.frames;
  assign pixel_clock_out_o = rl.pclk;
  assign hsync_o = rl.hs;
  assign vsync_o = rl.vs;
  assign data_valid_enable_o = rl.de;
  assign pix_data_o = rl.data;
  assign cs_n_o = rl.cs_n;
  assign wr_n_o = rl.wr_n;

endmodule

// ### dv/dstg_monitor.sv
`timescale 1ns/1ps
module dstg_monitor
  import dstg_pkg::*;
#(
  parameter int CW = CFG_W,
  parameter int PW = PIX_W
) (
  // control
  input wire logic rst_i,
  input wire logic display_internal_clock_i,
  input wire logic enable_i,
  input wire logic mode_i,
  input wire logic burst_i,
  input wire logic pol_clk_i,
  input wire logic pol_hs_i,
  input wire logic pol_vs_i,
  input wire logic pol_de_i,
  input wire logic [CW-1:0] h_total_i,
  input wire logic [CW-1:0] hs_up_i,
  input wire logic [CW-1:0] hs_down_i,
  // observed
  input wire logic active_o,
  input wire logic pixel_clock_out_o,
  input wire logic hsync_o,
  input wire logic vsync_o,
  input wire logic data_valid_enable_o,
  input wire logic [PW-1:0] pix_data_o,
  input wire logic cs_n_o,
  input wire logic wr_n_o
);
  // --------
  // helpers
  // --------
  logic hs_a, vs_a, run, hs_q, seen, hs_in, full;
  logic [CW-1:0] hs_len, hs_gap;
  assign hs_a = hsync_o ^ pol_hs_i;
  assign vs_a = vsync_o ^ pol_vs_i;
  // status lags the link side, so gate on both
  assign run = enable_i && active_o && !mode_i;
  always_ff @(posedge display_internal_clock_i or posedge rst_i) begin
    if (rst_i) begin
      hs_q <= 1'h0;
      seen <= 1'h0;
      hs_in <= 1'h0;
      full <= 1'h0;
      hs_len <= '0;
      hs_gap <= '0;
    end else begin
      hs_q <= hs_a;
      seen <= run && (seen || (hs_a && !hs_q));
      hs_in <= vs_a && (hs_in || (hs_a && !hs_q));
      full <= vs_a && (full || (hs_in && hs_q && !hs_a));
      hs_len <= hs_a ? hs_len + 1'h1 : '0;
      hs_gap <= (hs_a && !hs_q) ? CW'(1) : hs_gap + 1'h1;
    end
  end
  // --------
  // checks
  // --------
  default clocking dcb @(posedge display_internal_clock_i);
  endclocking
  default disable iff (rst_i);
  sequence s_single_wr;
    mode_i && !burst_i && !cs_n_o && !wr_n_o;
  endsequence
  sequence s_burst_wr;
    mode_i && burst_i && !cs_n_o && !wr_n_o;
  endsequence
  a_pclk_runs: assert property (run && $past(run, 2) |-> pixel_clock_out_o != $past(pixel_clock_out_o))
    else $error("pixel clock stalled");
  a_hs_width: assert property (run && $fell(hs_a) |-> hs_len == hs_down_i - hs_up_i)
    else $error("line sync width wrong");
  a_line_period: assert property (run && seen && $rose(hs_a) |-> hs_gap == h_total_i)
    else $error("line period wrong");
  a_vs_spans_hs: assert property (run && $fell(vs_a) |-> full)
    else $error("frame sync holds no whole line sync");
  a_data_blank: assert property (run && $past(run, 2) && !(data_valid_enable_o ^ pol_de_i) |-> pix_data_o == '0)
    else $error("data outside enable");
  a_data_phase: assert property (run && $past(run, 2) && pixel_clock_out_o == pol_clk_i |->
    $stable(pix_data_o) && $stable(data_valid_enable_o))
    else $error("data moved off phase");
  a_single_gap: assert property (s_single_wr |=> cs_n_o && wr_n_o)
    else $error("single access gap missing");
  a_burst_gap: assert property (s_burst_wr |=> !cs_n_o && wr_n_o)
    else $error("burst strobe wrong");
  a_par_idle: assert property (mode_i && active_o && $past(active_o, 2) |->
    {pixel_clock_out_o, hsync_o, vsync_o, data_valid_enable_o} == {pol_clk_i, pol_hs_i, pol_vs_i, pol_de_i})
    else $error("sync lines not idle");
endmodule

bind dstg_top dstg_monitor #(.CW(CW), .PW(PW)) mon_u (.rst_i, .display_internal_clock_i, .enable_i, .mode_i,
  .burst_i, .pol_clk_i, .pol_hs_i, .pol_vs_i, .pol_de_i, .h_total_i, .hs_up_i, .hs_down_i, .active_o,
  .pixel_clock_out_o, .hsync_o, .vsync_o, .data_valid_enable_o, .pix_data_o, .cs_n_o, .wr_n_o);

// ### dv/dstg_panel.sv
`timescale 1ns/1ps
module dstg_panel
  import dstg_pkg::*;
(
  // panel pins
  input wire logic pixel_clock_out_i,
  input wire logic data_valid_enable_i,
  input wire logic [PIX_W-1:0] pix_data_i,
  input wire logic wr_n_i,
  // straps
  input wire logic mode_i,
  input wire logic pol_clk_i,
  input wire logic pol_de_i
);
  logic [PIX_W-1:0] got[$];
  // capture edge follows the clock polarity strap
  always @(pixel_clock_out_i) begin
    if (!mode_i && pixel_clock_out_i === pol_clk_i && (data_valid_enable_i ^ pol_de_i) === 1'h1) begin
      got.push_back(pix_data_i);
    end
  end
  // trailing strobe edge, data still held in the gap
  always @(posedge wr_n_i) begin
    if (mode_i) begin
      got.push_back(pix_data_i);
    end
  end
endmodule

// ### dv/dstg_top_test.sv
`timescale 1ns/1ps
module dstg_top_test;
  import dstg_pkg::*;
  logic clk_i, rst_i, dclk, pix_valid_i, enable_i, mode_i, burst_i, underrun_clr_i;
  logic pol_clk_i, pol_hs_i, pol_vs_i, pol_de_i;
  logic [PIX_W-1:0] pix_data_i, pix_data_o;
  logic [CFG_W-1:0] h_total_i, hs_off_i, hs_up_i, hs_down_i, de_off_i, de_up_i, de_down_i;
  logic [CFG_W-1:0] v_total_i, vs_off_i, vs_up_i, vs_down_i, va_up_i, va_down_i;
  logic pix_ready_o, underrun_o, active_o, pixel_clock_out_o, hsync_o, vsync_o, data_valid_enable_o, cs_n_o, wr_n_o;
  logic [FRAME_CNT_W-1:0] frame_count_o;
  int fails, compares;

  dstg_top dut_u (.clk_i, .rst_i, .display_internal_clock_i(dclk), .pix_data_i, .pix_valid_i, .pix_ready_o,
    .enable_i, .mode_i, .burst_i, .pol_clk_i, .pol_hs_i, .pol_vs_i, .pol_de_i, .h_total_i, .hs_off_i, .hs_up_i,
    .hs_down_i, .de_off_i, .de_up_i, .de_down_i, .v_total_i, .vs_off_i, .vs_up_i, .vs_down_i, .va_up_i, .va_down_i,
    .underrun_clr_i, .underrun_o, .active_o, .frame_count_o, .pixel_clock_out_o, .hsync_o, .vsync_o,
    .data_valid_enable_o, .pix_data_o, .cs_n_o, .wr_n_o);
  dstg_panel panel_u (.pixel_clock_out_i(pixel_clock_out_o), .data_valid_enable_i(data_valid_enable_o),
    .pix_data_i(pix_data_o), .wr_n_i(wr_n_o), .mode_i, .pol_clk_i, .pol_de_i);

  // ------------
  // clocks
  // ------------
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    dclk = 1'h0;
    #7;
    forever #24 dclk = ~dclk;
  end

  // ------------
  // tasks
  // ------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task stuck;
    fails++;
    results();
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge dclk);
    @(posedge clk_i);
  endtask
  task automatic push(input logic [PIX_W-1:0] w);
    int k;
    pix_data_i <= w;
    pix_valid_i <= 1'h1;
    @(negedge clk_i);
    for (k = 0; k < 400 && pix_ready_o !== 1'h1; k++) @(negedge clk_i);
    if (k >= 400) stuck();
    @(posedge clk_i);
  endtask
  // 0 active, 1 underrun, 2 words at panel, 3 frames
  task automatic wait_on(input int sel, input int v);
    int k;
    for (k = 0; k < 4000; k++) begin
      @(posedge clk_i);
      if ((sel == 0 && active_o === v[0]) || (sel == 1 && underrun_o === v[0]) ||
          (sel == 2 && panel_u.got.size() >= v) || (sel == 3 && frame_count_o >= v)) break;
    end
    if (k >= 4000) stuck();
  endtask

  // ------------
  // sequence
  // ------------
  initial begin
    {rst_i, pix_valid_i, enable_i, mode_i, burst_i, underrun_clr_i} = 6'h20;
    {pol_clk_i, pol_hs_i, pol_vs_i, pol_de_i, pix_data_i} = '0;
    {h_total_i, hs_off_i, hs_up_i, hs_down_i} = {12'h008, 12'h000, 12'h001, 12'h003};
    {de_off_i, de_up_i, de_down_i, v_total_i} = {12'h000, 12'h002, 12'h006, 12'h004};
    {vs_off_i, vs_up_i, vs_down_i, va_up_i, va_down_i} = {12'h000, 12'h001, 12'h002, 12'h000, 12'h004};
    go(2);
    rst_i <= 1'h0;
    {pol_clk_i, pol_hs_i, pol_vs_i, pol_de_i} <= 4'hF;
    go(4);
    chk("idle", {pixel_clock_out_o, hsync_o, vsync_o, data_valid_enable_o, cs_n_o, wr_n_o}, 32'h3F);
    $display("idle test done");
    // second pass runs the inverted clock, active-low syncs and a line sync offset
    for (int p = 0; p < 2; p++) begin
      {pol_clk_i, pol_hs_i, pol_vs_i, pol_de_i} <= {4{p[0]}};
      hs_off_i <= CFG_W'(2 * p);
      for (int i = 0; i < 8; i++) push(16'hA000 + PIX_W'(i));
      pix_data_i <= 16'hA0FF;
      go(3);
      chk("ready", pix_ready_o, 32'h0);
      pix_valid_i <= 1'h0;
      // a polarity swap while stopped can look like a capture edge
      panel_u.got.delete();
      enable_i <= 1'h1;
      wait_on(2, 9);
      for (int i = 0; i < 8; i++) chk("pixel", panel_u.got[i], 32'hA000 + i);
      chk("blank", panel_u.got[8], 32'h0);
      wait_on(3, int'(frame_count_o) + 2);
      chk("underrun", underrun_o, 32'h1);
      enable_i <= 1'h0;
      wait_on(0, 0);
      underrun_clr_i <= 1'h1;
      go(1);
      underrun_clr_i <= 1'h0;
      go(1);
      chk("underrun clr", underrun_o, 32'h0);
      chk("stopped", {pixel_clock_out_o, data_valid_enable_o}, {30'h0, {2{p[0]}}});
      $display("panel test done, polarity %0d", p);
    end
    for (int b = 0; b < 2; b++) begin
      panel_u.got.delete();
      {mode_i, burst_i, pol_clk_i, pol_hs_i, pol_vs_i, pol_de_i} <= {1'h1, b[0], 4'hF};
      for (int i = 0; i < 3; i++) push(16'hC000 + PIX_W'(i));
      pix_valid_i <= 1'h0;
      go(4);
      enable_i <= 1'h1;
      wait_on(2, 3);
      for (int i = 0; i < 3; i++) chk("word", panel_u.got[i], 32'hC000 + i);
      enable_i <= 1'h0;
      wait_on(0, 0);
      go(2);
      chk("strobes idle", {cs_n_o, wr_n_o}, 32'h3);
      $display("parallel test done, burst %0d", b);
    end
    results();
  end
endmodule
